// >>> npc_config.sv
// Commit-page select, slow power-up control and crystal load-cap readback
// Notes on behaviour
// - Commit-page field steers register image store
// - Six pages; two pins pick power-up page
// - Slow power-up bits at two and six
// - Slow plus bandwidth bits extend start 60ms
// - Ten-bit load-cap readback split, upper six bits read zero
// - Common bits first, then six page regions
// - Device fills bytes zero to ten itself
`timescale 1ns/100ps
module npc_config
   import npc_pkg::*;
#(
   parameter int SLOW_CYC = SLOW_POR_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register access from the serial configuration front end
   input npc_req_t busReq,
   output npc_rsp_t busRsp,
   // Power-up page select pins, asynchronous
   input wire logic [1:0] pageSelPin,
   // Loop bandwidth bits held elsewhere
   input wire logic synthOneLoopBw,
   input wire logic synthTwoLoopBw,
   // Crystal load-cap value from the oscillator block
   input wire logic [9:0] crystalLoadCapIn,
   // Store engine interface
   input wire logic storeOpReq,
   output logic storeStart,
   output logic [3:0] storePage,
   output logic [8:0] nvmAutoLast,
   // Power-on status
   output logic [3:0] bootPage,
   output logic porDone
);
   // Pin synchroniser: only the second stage is ever decoded
   logic [1:0] pinMeta_ff; // First stage, may settle late
   logic [1:0] pinSync_ff; // Second stage, read by the sequencer
   // Software-visible register state
   logic [3:0] commitPage_ff, nxt_commitPage; // Commit page, kept raw
   logic slowOne_ff, nxt_slowOne; // Slow ramp bit, synthesizer one
   logic slowTwo_ff, nxt_slowTwo; // Slow ramp bit, synthesizer two
   logic [9:0] xcap_ff, nxt_xcap; // Load-cap readback, sampled every cycle
   npc_rsp_t rsp_ff, nxt_rsp; // Registered read answer
   logic storeStart_ff, nxt_storeStart; // Store launch, storeOpReq delayed one cycle
   logic [3:0] storePage_ff, nxt_storePage; // Page the store engine fills
   logic [8:0] autoLast_ff, nxt_autoLast; // Last device-owned store byte
   // Retained copy of both slow bits; stands in for the nonvolatile store
   logic [1:0] slowKeep_ff, nxt_slowKeep;
   // Power-on sequencer
   npc_por_t por_ff, nxt_por; // Sequencer state
   logic [31:0] cnt_ff, nxt_cnt; // Extension cycle count
   logic [3:0] bootPage_ff, nxt_bootPage; // Page picked by the pins
   logic porDone_ff, nxt_porDone; // Start-up complete

   // Clamp a page number into the valid range; out-of-range values are unsupported, so page zero is used
   function automatic logic [3:0] clampPage(input logic [3:0] p);
      clampPage = (p > PAGE_LAST) ? 4'h0 : p;
   endfunction : clampPage

   // Two flops on the page pins. They carry no reset on purpose: the pins
   // keep flowing in while reset is held, so the sequencer sees a settled
   // page at the first edge after release instead of a cleared value.
   always_ff @(posedge clk) begin
      pinMeta_ff <= pageSelPin;
      pinSync_ff <= pinMeta_ff;
   end

   // Register writes, read mux, store launch
   always_comb begin
      // Hold by default; the load-cap readback and store launch follow their sources every cycle, the read answer clears
      nxt_commitPage = commitPage_ff;
      nxt_slowOne = slowOne_ff;
      nxt_slowTwo = slowTwo_ff;
      nxt_slowKeep = slowKeep_ff;
      nxt_xcap = crystalLoadCapIn;
      nxt_rsp = '0;
      nxt_storeStart = storeOpReq;
      nxt_storePage = storePage_ff;
      nxt_autoLast = NVM_AUTO_LAST;
      // Writes: only defined bits store
      if (busReq.wrEn) begin
         case (busReq.addr)
            // Any 4-bit value is kept; the clamp acts only when a store is launched
            OFS_COMMIT_PAGE: nxt_commitPage = busReq.wdata[3:0];
            OFS_POR_CTRL: begin
               // Both slow bits; reserved positions are dropped
               nxt_slowOne = busReq.wdata[POS_SLOW_ONE];
               nxt_slowTwo = busReq.wdata[POS_SLOW_TWO];
               // The retained copy follows every write so the next start sees it
               nxt_slowKeep = {busReq.wdata[POS_SLOW_TWO], busReq.wdata[POS_SLOW_ONE]};
            end
            default: ; // Read-only or unmapped
         endcase
      end
      // Reads: reserved bits zero, unmapped reads zero
      if (busReq.rdEn) begin
         nxt_rsp.rdValid = 1'b1;
         case (busReq.addr)
            // Upper nibble is reserved and reads zero
            OFS_COMMIT_PAGE: nxt_rsp.rdata = {4'h0, commitPage_ff};
            // Slow bits in place, reserved bits zero
            OFS_POR_CTRL: nxt_rsp.rdata = {1'b0, slowTwo_ff, 3'h0, slowOne_ff, 2'h0};
            // Load-cap value; the two halves are not read atomically
            OFS_XCAP_HIGH: nxt_rsp.rdata = {6'h00, xcap_ff[9:8]};
            OFS_XCAP_LOW: nxt_rsp.rdata = xcap_ff[7:0];
            default: nxt_rsp.rdata = 8'h00; // Unmapped
         endcase
      end
      // Latch target page with the store pulse; region = common area then page
      if (storeOpReq) begin
         nxt_storePage = clampPage(commitPage_ff);
      end
   end

   // Register state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         commitPage_ff <= RST_COMMIT_PAGE;
         slowOne_ff <= RST_SLOW_ONE;
         slowTwo_ff <= RST_SLOW_TWO;
         xcap_ff <= RST_XCAP;
         rsp_ff <= '0;
         storeStart_ff <= 1'b0;
         storePage_ff <= RST_COMMIT_PAGE;
         autoLast_ff <= NVM_AUTO_LAST;
      end else begin
         commitPage_ff <= nxt_commitPage;
         slowOne_ff <= nxt_slowOne;
         slowTwo_ff <= nxt_slowTwo;
         xcap_ff <= nxt_xcap;
         rsp_ff <= nxt_rsp;
         storeStart_ff <= nxt_storeStart;
         storePage_ff <= nxt_storePage;
         autoLast_ff <= nxt_autoLast;
      end
   end

   // Retained slow bits: not cleared by reset, like the nonvolatile copy they model.
   // Until software first writes them they hold whatever the store held, so the
   // very first start after power-up may or may not be stretched.
   always_ff @(posedge clk) begin
      slowKeep_ff <= nxt_slowKeep;
   end

   // Power-on sequence: capture boot page, optional slow extension.
   // The decision is taken once, at the first edge after reset; later writes
   // to the slow bits only take effect at the next start.
   always_comb begin
      // Hold by default
      nxt_por = por_ff;
      nxt_cnt = cnt_ff;
      nxt_bootPage = bootPage_ff;
      case (por_ff)
         PorWait: begin
            // Pins pick one of the first four of six pages
            nxt_bootPage = {2'h0, pinSync_ff};
            nxt_cnt = 32'h0;
            // Stretch only when a slow bit and both bandwidth bits are set
            if ((slowKeep_ff[0] || slowKeep_ff[1]) && synthOneLoopBw && synthTwoLoopBw) begin
               nxt_por = PorExtend;
            end else begin
               nxt_por = PorDone;
            end
         end
         PorExtend: begin
            // Count out the slow ramp delay
            if (cnt_ff >= 32'(SLOW_CYC - 1)) begin
               nxt_por = PorDone;
            end else begin
               nxt_cnt = cnt_ff + 32'h1;
            end
         end
         // Terminal until the next reset
         PorDone: nxt_por = PorDone;
         // Unused code: restart the sequence
         default: nxt_por = PorWait;
      endcase
      // Done flag registered with the state so the output comes from a flop
      nxt_porDone = (nxt_por == PorDone);
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         por_ff <= PorWait;
         cnt_ff <= 32'h0;
         bootPage_ff <= RST_COMMIT_PAGE;
         porDone_ff <= 1'b0;
      end else begin
         por_ff <= nxt_por;
         cnt_ff <= nxt_cnt;
         bootPage_ff <= nxt_bootPage;
         porDone_ff <= nxt_porDone;
      end
   end

   // Outputs, all straight from flops; bytes 0..10 belong to the device-owned area
   assign busRsp = rsp_ff;
   assign storeStart = storeStart_ff;
   assign storePage = storePage_ff;
   assign nvmAutoLast = autoLast_ff;
   assign bootPage = bootPage_ff;
   assign porDone = porDone_ff;
endmodule : npc_config

// >>> npc_config_sva.sv
// Checker for the page-commit config block
`timescale 1ns/100ps
module npc_config_sva import npc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register bus
   input npc_req_t busReq,
   input npc_rsp_t busRsp,
   // Pins and levels
   input wire logic [1:0] pageSelPin,
   input wire logic synthOneLoopBw,
   input wire logic synthTwoLoopBw,
   input wire logic [9:0] crystalLoadCapIn,
   // Store and status
   input wire logic storeOpReq,
   input wire logic storeStart,
   input wire logic [3:0] storePage,
   input wire logic [8:0] nvmAutoLast,
   input wire logic [3:0] bootPage,
   input wire logic porDone
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   store_pulse_a: assert property (storeOpReq |=> storeStart) else $error("store late");
   store_range_a: assert property (storeStart |-> storePage <= PAGE_LAST) else $error("store page");
   boot_page_a: assert property (porDone |-> bootPage[3:2] == 2'b00) else $error("boot page");
   ramp_bits_a: assert property (busReq.rdEn && busReq.addr == OFS_POR_CTRL |=>
      !(|(busRsp.rdata & 8'hbb))) else $error("ramp bits");
   por_hold_a: assert property (porDone |=> porDone) else $error("por dropped");
   // Load-cap reads only count once the readback has settled after reset
   cap_high_a: assert property (busReq.rdEn && busReq.addr == OFS_XCAP_HIGH && $past(rst_b, 2) &&
      $stable(crystalLoadCapIn) |=> busRsp.rdata == {6'h00, $past(crystalLoadCapIn[9:8])}) else $error("cap hi");
   cap_low_a: assert property (busReq.rdEn && busReq.addr == OFS_XCAP_LOW && $past(rst_b, 2) &&
      $stable(crystalLoadCapIn) |=> busRsp.rdata == $past(crystalLoadCapIn[7:0])) else $error("cap lo");
   auto_last_a: assert property (nvmAutoLast == NVM_AUTO_LAST) else $error("auto last");
   c_store: cover property (storeStart);
   c_por: cover property ($rose(porDone));
   c_read: cover property (busRsp.rdValid);
   c_slow: cover property (!porDone ##1 !porDone ##1 !porDone ##1 porDone);
endmodule : npc_config_sva
bind npc_config npc_config_sva npc_config_sva_i (.*);

// >>> npc_host.sv
// Host model issuing register bus cycles
`timescale 1ns/100ps
module npc_host import npc_pkg::*; (
   // Clock
   input wire logic clk,
   // Register bus
   output npc_req_t req,
   input npc_rsp_t rsp
);
   initial req = '{1'b0, 1'b0, 8'h00, 8'h00};
   // Register offsets and one unmapped offset are reached, never device-owned store bytes
   // Page values come from the bench within legal ranges; ramp values are random bytes
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [8:0] q);
      @(negedge clk);
      req = '{w, !w, a, d};
      @(negedge clk);
      q = rsp;
      // Idle fields show the inverse so stale values never look valid
      req = '{1'b0, 1'b0, ~a, ~d};
   endtask : acc
endmodule : npc_host

// >>> npc_pkg.sv
// Package with register map, field layout and timing constants for the page-commit config block
package npc_pkg;
   // Register offsets on the configuration bus
   localparam logic [7:0] OFS_COMMIT_PAGE = 8'h91;
   localparam logic [7:0] OFS_POR_CTRL = 8'had;
   localparam logic [7:0] OFS_XCAP_HIGH = 8'hc7;
   localparam logic [7:0] OFS_XCAP_LOW = 8'hc8;
   // Field positions
   localparam int POS_SLOW_ONE = 2;
   localparam int POS_SLOW_TWO = 6;
   // Reset values
   localparam logic [3:0] RST_COMMIT_PAGE = 4'h0;
   localparam logic RST_SLOW_ONE = 1'b0;
   localparam logic RST_SLOW_TWO = 1'b0;
   localparam logic [9:0] RST_XCAP = 10'h000;
   // Page layout
   localparam logic [3:0] PAGE_COUNT = 4'h6;
   localparam logic [3:0] PAGE_LAST = 4'h5;
   localparam logic [8:0] NVM_AUTO_LAST = 9'h00a;
   localparam logic [8:0] NVM_USER_LAST = 9'h158;
   // Power-on extension time
   localparam int CLK_MHZ = 250;
   localparam int SLOW_POR_MS = 60;
   localparam int SLOW_POR_CYC = SLOW_POR_MS * 1000 * CLK_MHZ;
   // Register bus request and answer
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wdata;
   } npc_req_t;
   typedef struct packed {
      logic rdValid;
      logic [7:0] rdata;
   } npc_rsp_t;
   // Power-on sequence states
   typedef enum logic [1:0] {PorWait, PorExtend, PorDone} npc_por_t;
endpackage : npc_pkg

// >>> test_npc_config.sv
// Testbench for the page-commit config block
`timescale 1ns/100ps
module test_npc_config import npc_pkg::*;;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   npc_req_t busReq;
   npc_rsp_t busRsp;
   logic [1:0] pageSelPin = 2'b00;
   logic synthOneLoopBw = 1'b1;
   logic synthTwoLoopBw = 1'b1;
   logic [9:0] crystalLoadCapIn = 10'h000;
   logic storeOpReq = 1'b0;
   logic storeStart, porDone;
   logic [3:0] storePage, bootPage;
   logic [8:0] nvmAutoLast, q;
   int err_total = 0, checks = 0, seed = 32'h7ee142a8, v, n;
   // Behavioural model: software registers and the queue of expected store pages
   int pageM = 0, rampM = 0;
   int storeQ[$];
   // Short extension count keeps the run brief
   localparam int SLOW_SIM = 20;
   always #2 clk = ~clk;
   npc_config #(.SLOW_CYC(SLOW_SIM)) npc_config_i (.clk(clk), .rst_b(rst_b), .busReq(busReq), .busRsp(busRsp),
      .pageSelPin(pageSelPin), .synthOneLoopBw(synthOneLoopBw), .synthTwoLoopBw(synthTwoLoopBw),
      .crystalLoadCapIn(crystalLoadCapIn), .storeOpReq(storeOpReq), .storeStart(storeStart),
      .storePage(storePage), .nvmAutoLast(nvmAutoLast), .bootPage(bootPage), .porDone(porDone));
   npc_host npc_host_i (.clk(clk), .req(busReq), .rsp(busRsp));
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // Read answers carry the valid bit above the data
   task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
      npc_host_i.acc(1'b0, a, 8'h00, q);
      chk(n, {2'b01, e}, {1'b0, q});
   endtask : rd
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test
   // Pins change only under reset, so the boot page is known
   // ext: the retained slow bits and both bandwidth bits ask for a stretched start
   task automatic do_reset(input bit ext);
      @(negedge clk);
      rst_b = 1'b0;
      pageSelPin = 2'($random(seed));
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      pageM = 0;
      rampM = 0;
      repeat (2) @(negedge clk);
      chk("porDone", {9'h000, !ext}, {9'h000, porDone});
      chk("bootPage", {8'h00, pageSelPin}, {6'h00, bootPage});
      // Bounded wait; a stretched start ends after the count plus the decision cycle
      n = 2;
      while (!porDone && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("porCycles", ext ? 10'(SLOW_SIM + 1) : 10'h002, 10'(n));
      if (n >= 100) finish_test();
      rd("pageRst", OFS_COMMIT_PAGE, 8'(pageM));
   endtask : do_reset
   initial begin
      do_reset(1'b0);
      chk("autoLast", 10'h00a, {1'b0, nvmAutoLast});
      rd("rampRst", OFS_POR_CTRL, 8'(rampM));
      for (int p = 0; p < 6; p++) begin
         npc_host_i.acc(1'b1, OFS_COMMIT_PAGE, 8'(p), q);
         pageM = p;
         rd("page", OFS_COMMIT_PAGE, 8'(pageM));
         @(negedge clk);
         storeOpReq = 1'b1;
         storeQ.push_back(pageM);
         @(negedge clk);
         storeOpReq = 1'b0;
         chk("storeStart", 10'h001, {9'h000, storeStart});
         chk("storePage", 10'(storeQ.pop_front()), {6'h00, storePage});
         @(negedge clk);
         chk("storeEnd", 10'h000, {9'h000, storeStart});
      end
      repeat (4) begin
         v = $random(seed);
         npc_host_i.acc(1'b1, OFS_POR_CTRL, 8'(v), q);
         rampM = v & 32'h44;
         rd("ramp", OFS_POR_CTRL, 8'(rampM));
      end
      repeat (3) begin
         @(negedge clk);
         crystalLoadCapIn = 10'($random(seed));
         // Writes to the readback must be ignored
         npc_host_i.acc(1'b1, OFS_XCAP_LOW, 8'hff, q);
         rd("capHigh", OFS_XCAP_HIGH, {6'h00, crystalLoadCapIn[9:8]});
         rd("capLow", OFS_XCAP_LOW, crystalLoadCapIn[7:0]);
      end
      rd("unmapped", 8'h90, 8'h00);
      // Both slow bits with both bandwidth bits set: the next start is stretched
      npc_host_i.acc(1'b1, OFS_POR_CTRL, 8'h44, q);
      do_reset(1'b1);
      // Slow bits kept but one bandwidth bit clear: short start
      synthTwoLoopBw = 1'b0;
      do_reset(1'b0);
      synthTwoLoopBw = 1'b1;
      npc_host_i.acc(1'b1, OFS_POR_CTRL, 8'h00, q);
      do_reset(1'b0);
      finish_test();
   end
endmodule : test_npc_config
